// ==== logic/eag_pkg.sv ====
// Package for the effective address generator.
// Assumes a 32-bit core with 16-bit instruction words.
package eag_pkg;
  // Instruction and data widths
  localparam int EAG_IW = 16;
  localparam int EAG_DW = 32;
  // Operand size select codes
  localparam logic [1:0] EAG_SZ_BYTE = 2'h0;
  localparam logic [1:0] EAG_SZ_WORD = 2'h1;
  localparam logic [1:0] EAG_SZ_LONG = 2'h2;
  // Field positions inside the instruction word
  localparam int EAG_DST_LSB = 8;
  localparam int EAG_SRC_LSB = 4;
  localparam int EAG_D4_LSB = 0;
  localparam int EAG_D8_LSB = 0;
  localparam int EAG_D12_LSB = 0;
  // Long access PC mask
  localparam logic [31:0] EAG_PC_LONG_MASK = 32'hfffffffc;
  // Reset value of address outputs
  localparam logic [31:0] EAG_RST_WORD = 32'h0000_0000;

  // Addressing mode select, one-hot
  typedef enum logic [13:0] {
    EAG_M_REG_DIRECT = 14'h0001,
    EAG_M_REG_IND = 14'h0002,
    EAG_M_POST_INC = 14'h0004,
    EAG_M_PRE_DEC = 14'h0008,
    EAG_M_REG_DISP = 14'h0010,
    EAG_M_INDEXED = 14'h0020,
    EAG_M_GBR_DISP = 14'h0040,
    EAG_M_GBR_INDEX = 14'h0080,
    EAG_M_PC_DISP = 14'h0100,
    EAG_M_BR_SHORT = 14'h0200,
    EAG_M_BR_LONG = 14'h0400,
    EAG_M_BR_REG = 14'h0800,
    EAG_M_IMM = 14'h1000,
    EAG_M_MAC = 14'h2000
  } eag_mode_t;

  // Immediate handling select, one-hot
  typedef enum logic [2:0] {
    EAG_I_ZERO = 3'h1,
    EAG_I_SIGN = 3'h2,
    EAG_I_TRAP = 3'h4
  } eag_imm_t;
endpackage

// ==== logic/eag_field_if.sv ====
// Interface carrying fields decoded from one instruction word.
// Assumes a single clock domain; pure wiring.
`timescale 1ns/100ps
`default_nettype none
interface eag_field_if;
  import eag_pkg::*;
  logic [3:0] dst_idx; // Destination register field
  logic [3:0] src_idx; // Source register field
  logic [3:0] disp4; // Short displacement
  logic [7:0] disp8; // Byte displacement or immediate
  logic [11:0] disp12; // Long branch displacement
  modport ext (output dst_idx, src_idx, disp4, disp8, disp12);
  modport use_side (input dst_idx, src_idx, disp4, disp8, disp12);
endinterface
`default_nettype wire

// ==== logic/eag_field_ext.sv ====
// Field extractor: splits one instruction word into its fields.
// Assumes the word is stable in the cycle it is presented.
`timescale 1ns/100ps
`default_nettype none
module eag_field_ext
  import eag_pkg::*;
(
  input wire logic [EAG_IW-1:0] instr,
  eag_field_if.ext fld
);
  // RULE18: fields from one word
  always_comb begin
    fld.dst_idx = instr[EAG_DST_LSB +: 4];
    fld.src_idx = instr[EAG_SRC_LSB +: 4];
    fld.disp4 = instr[EAG_D4_LSB +: 4];
    // RULE17: low byte displacement
    fld.disp8 = instr[EAG_D8_LSB +: 8];
    fld.disp12 = instr[EAG_D12_LSB +: 12];
  end
endmodule
`default_nettype wire

// ==== logic/eag_top.sv ====
// Effective address generator: operand addresses, branch targets,
// extended immediates and implied register write-backs.
// Assumes decode supplies mode, size and register values same clock.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// RULE1: register direct gives register, no access
// RULE2: indirect address is register unchanged
// RULE3: post-increment uses register, then adds size
// RULE4: pre-decrement subtracts size, writes, uses it
// RULE5: register plus size-scaled 4-bit displacement
// RULE6: indexed address is register plus zero
// RULE7: global base plus scaled zero-extended byte
// RULE8: global base plus index register zero
// RULE9: PC plus scaled byte, long masks PC
// RULE10: short branch PC plus signed byte doubled
// RULE11: long branch PC plus signed 12-bit doubled
// RULE12: register branch PC plus source register
// RULE13: test and logic immediates zero-extended
// RULE14: move add compare immediates sign-extended
// RULE15: trap vector offset immediate times four
// RULE16: multiply-accumulate post-increments both registers
// RULE17: PC load byte displacement, register above
// RULE18: all fields from one 16-bit word
// RULE19: size select alone sets scale, step
module eag_top
  import eag_pkg::*;
#(
  parameter int DW = EAG_DW
)
(
  // Clock, reset and enable
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  // Request from the decode stage
  input wire logic op_valid,
  input wire logic [EAG_IW-1:0] instr,
  input wire logic [13:0] mode_sel,
  input wire logic [2:0] imm_sel,
  input wire logic [1:0] size_sel,
  // Register values read for this word
  input wire logic [DW-1:0] source_general_register,
  input wire logic [DW-1:0] destination_general_register,
  input wire logic [DW-1:0] index_register_zero,
  input wire logic [DW-1:0] global_base_register,
  input wire logic [DW-1:0] pc_value,
  // Results towards the memory access stage
  output logic res_valid_q,
  output logic [DW-1:0] ea_q,
  output logic mem_access_q,
  output logic [DW-1:0] operand_q,
  output logic operand_valid_q,
  output logic [DW-1:0] target_q,
  output logic target_valid_q,
  output logic [DW-1:0] imm_q,
  output logic imm_valid_q,
  // Implied register write-backs
  output logic wb_a_en_q,
  output logic [3:0] wb_a_idx_q,
  output logic [DW-1:0] wb_a_data_q,
  output logic wb_b_en_q,
  output logic [3:0] wb_b_idx_q,
  output logic [DW-1:0] wb_b_data_q,
  output logic mac_dest_q
);

  // Decoded fields of the current word
  eag_field_if fld ();

  // Field extractor instance
  eag_field_ext u_ext (
    .instr(instr),
    .fld(fld)
  );

  // Size-driven step and scale, from the size select only
  // RULE19: size select sets step
  function automatic logic [DW-1:0] size_step(input logic [1:0] sz);
    case (sz)
      EAG_SZ_BYTE: size_step = DW'(1);
      EAG_SZ_WORD: size_step = DW'(2);
      EAG_SZ_LONG: size_step = DW'(4);
      default: size_step = DW'(4);
    endcase
  endfunction

  // Zero-extend a displacement and scale it by operand size
  function automatic logic [DW-1:0] scale_disp(input logic [7:0] d,
                                               input logic [1:0] sz);
    logic [DW-1:0] z;
    z = {{(DW-8){1'b0}}, d};
    case (sz)
      EAG_SZ_BYTE: scale_disp = z;
      EAG_SZ_WORD: scale_disp = {z[DW-2:0], 1'b0};
      EAG_SZ_LONG: scale_disp = {z[DW-3:0], 2'b00};
      default: scale_disp = {z[DW-3:0], 2'b00};
    endcase
  endfunction

  // Combinational results
  logic [DW-1:0] ea_d; // Operand address
  logic mem_d; // Memory access implied
  logic [DW-1:0] oper_d; // Register operand
  logic oper_v_d; // Register operand valid
  logic [DW-1:0] tgt_d; // Branch target
  logic tgt_v_d; // Branch target valid
  logic [DW-1:0] imm_d; // Extended immediate
  logic imm_v_d; // Immediate valid
  logic wa_en_d; // Write-back A enable
  logic [3:0] wa_idx_d; // Write-back A register
  logic [DW-1:0] wa_dat_d; // Write-back A value
  logic wb_en_d; // Write-back B enable
  logic [3:0] wb_idx_d; // Write-back B register
  logic [DW-1:0] wb_dat_d; // Write-back B value
  logic mac_d; // Result goes to MAC pair
  logic [DW-1:0] step; // Size step
  logic [DW-1:0] dec_val; // Pre-decremented value
  logic [DW-1:0] pc_base; // PC, masked for long
  logic [DW-1:0] br8; // Signed short branch offset
  logic [DW-1:0] br12; // Signed long branch offset

  // Shared terms
  always_comb begin
    step = size_step(size_sel);
    dec_val = destination_general_register - step;
    // Mask only for long; byte and word keep the low PC bits
    // RULE9: long masks PC
    pc_base = (size_sel == EAG_SZ_LONG) ? (pc_value & EAG_PC_LONG_MASK)
                                        : pc_value;
    // RULE10: signed byte doubled
    br8 = {{(DW-9){fld.disp8[7]}}, fld.disp8, 1'b0};
    // RULE11: signed 12-bit doubled
    br12 = {{(DW-13){fld.disp12[11]}}, fld.disp12, 1'b0};
  end

  // Address and write-back selection by mode
  always_comb begin
    ea_d = EAG_RST_WORD;
    mem_d = 1'b0;
    oper_d = EAG_RST_WORD;
    oper_v_d = 1'b0;
    tgt_d = EAG_RST_WORD;
    tgt_v_d = 1'b0;
    wa_en_d = 1'b0;
    wa_idx_d = fld.src_idx;
    wa_dat_d = EAG_RST_WORD;
    wb_en_d = 1'b0;
    wb_idx_d = fld.dst_idx;
    wb_dat_d = EAG_RST_WORD;
    mac_d = 1'b0;
    // Unknown or mixed selects fall to default: no access at all
    case (mode_sel)
      // RULE1: operand from register
      EAG_M_REG_DIRECT: begin
        oper_d = source_general_register;
        oper_v_d = 1'b1;
      end
      // RULE2: address is register
      EAG_M_REG_IND: begin
        ea_d = source_general_register;
        mem_d = 1'b1;
      end
      // RULE3: use then increment
      EAG_M_POST_INC: begin
        ea_d = source_general_register;
        mem_d = 1'b1;
        wa_en_d = 1'b1;
        wa_dat_d = source_general_register + step;
      end
      // RULE4: decrement, write, use
      EAG_M_PRE_DEC: begin
        ea_d = dec_val;
        mem_d = 1'b1;
        wb_en_d = 1'b1;
        wb_dat_d = dec_val;
      end
      // RULE5: register plus scaled disp
      EAG_M_REG_DISP: begin
        ea_d = source_general_register +
               scale_disp({4'h0, fld.disp4}, size_sel);
        mem_d = 1'b1;
      end
      // RULE6: register plus index zero
      EAG_M_INDEXED: begin
        ea_d = source_general_register + index_register_zero;
        mem_d = 1'b1;
      end
      // RULE7: global base plus scaled byte
      EAG_M_GBR_DISP: begin
        ea_d = global_base_register + scale_disp(fld.disp8, size_sel);
        mem_d = 1'b1;
      end
      // RULE8: global base plus zero
      EAG_M_GBR_INDEX: begin
        ea_d = global_base_register + index_register_zero;
        mem_d = 1'b1;
      end
      // RULE9: PC plus scaled byte
      // RULE17: destination field above byte
      EAG_M_PC_DISP: begin
        ea_d = pc_base + scale_disp(fld.disp8, size_sel);
        mem_d = 1'b1;
      end
      // RULE10: short branch target
      EAG_M_BR_SHORT: begin
        tgt_d = pc_value + br8;
        tgt_v_d = 1'b1;
      end
      // RULE11: long branch target
      EAG_M_BR_LONG: begin
        tgt_d = pc_value + br12;
        tgt_v_d = 1'b1;
      end
      // RULE12: PC plus register
      EAG_M_BR_REG: begin
        tgt_d = pc_value + source_general_register;
        tgt_v_d = 1'b1;
      end
      // RULE16: both pointers post-increment
      EAG_M_MAC: begin
        ea_d = source_general_register;
        mem_d = 1'b1;
        wa_en_d = 1'b1;
        wa_dat_d = source_general_register + step;
        wb_en_d = 1'b1;
        wb_dat_d = destination_general_register + step;
        mac_d = 1'b1;
      end
      // Immediate mode handled below
      EAG_M_IMM: begin
        mem_d = 1'b0;
      end
      // Unknown select: no action
      default: begin
        mem_d = 1'b0;
      end
    endcase
  end

  // Immediate extension
  always_comb begin
    imm_v_d = (mode_sel == EAG_M_IMM);
    case (imm_sel)
      // RULE13: zero-extend logic immediates
      EAG_I_ZERO: imm_d = {{(DW-8){1'b0}}, fld.disp8};
      // RULE14: sign-extend arithmetic immediates
      EAG_I_SIGN: imm_d = {{(DW-8){fld.disp8[7]}}, fld.disp8};
      // RULE15: trap offset times four
      EAG_I_TRAP: imm_d = {{(DW-10){1'b0}}, fld.disp8, 2'b00};
      // Unknown select: zero
      default: imm_d = EAG_RST_WORD;
    endcase
  end

  // Result valid strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      res_valid_q <= 1'b0;
    end else if (clk_en) begin
      res_valid_q <= op_valid;
    end
  end

  // Operand address and memory access flag
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ea_q <= EAG_RST_WORD;
      mem_access_q <= 1'b0;
    end else if (clk_en) begin
      ea_q <= ea_d;
      mem_access_q <= op_valid & mem_d;
    end
  end

  // Register direct operand
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      operand_q <= EAG_RST_WORD;
      operand_valid_q <= 1'b0;
    end else if (clk_en) begin
      operand_q <= oper_d;
      operand_valid_q <= op_valid & oper_v_d;
    end
  end

  // Branch target
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      target_q <= EAG_RST_WORD;
      target_valid_q <= 1'b0;
    end else if (clk_en) begin
      target_q <= tgt_d;
      target_valid_q <= op_valid & tgt_v_d;
    end
  end

  // Extended immediate
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      imm_q <= EAG_RST_WORD;
      imm_valid_q <= 1'b0;
    end else if (clk_en) begin
      imm_q <= imm_d;
      imm_valid_q <= op_valid & imm_v_d;
    end
  end

  // Result routed to the multiply-accumulate pair
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mac_dest_q <= 1'b0;
    end else if (clk_en) begin
      mac_dest_q <= op_valid & mac_d;
    end
  end

  // Write-back of the source pointer
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wb_a_en_q <= 1'b0;
      wb_a_idx_q <= 4'h0;
      wb_a_data_q <= EAG_RST_WORD;
    end else if (clk_en) begin
      wb_a_en_q <= op_valid & wa_en_d;
      wb_a_idx_q <= wa_idx_d;
      wb_a_data_q <= wa_dat_d;
    end
  end

  // Write-back of the destination pointer
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wb_b_en_q <= 1'b0;
      wb_b_idx_q <= 4'h0;
      wb_b_data_q <= EAG_RST_WORD;
    end else if (clk_en) begin
      wb_b_en_q <= op_valid & wb_en_d;
      wb_b_idx_q <= wb_idx_d;
      wb_b_data_q <= wb_dat_d;
    end
  end
endmodule
`default_nettype wire

// ==== test/eag_chk.sv ====
// Checker for the address generator outputs.
// Assumes it is bound to eag_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module eag_chk
  import eag_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic op_valid,
  input wire logic [15:0] instr,
  input wire logic [13:0] mode_sel,
  input wire logic [2:0] imm_sel,
  input wire logic [1:0] size_sel,
  input wire logic [31:0] source_general_register,
  input wire logic [31:0] destination_general_register,
  input wire logic [31:0] index_register_zero,
  input wire logic [31:0] global_base_register,
  input wire logic [31:0] pc_value,
  input wire logic [31:0] ea_q,
  input wire logic mem_access_q,
  input wire logic [31:0] operand_q,
  input wire logic [31:0] target_q,
  input wire logic [31:0] imm_q,
  input wire logic wb_a_en_q,
  input wire logic [31:0] wb_a_data_q,
  input wire logic wb_b_en_q,
  input wire logic [31:0] wb_b_data_q,
  input wire logic mac_dest_q
);
  // Short names for the register values
  wire logic [31:0] rs = source_general_register;
  wire logic [31:0] rd = destination_general_register;
  wire logic [31:0] pc = pc_value;
  // Size step: 1, 2 or 4 bytes
  wire logic [31:0] st = size_sel == 2'h0 ? 32'h1 :
    size_sel == 2'h1 ? 32'h2 : 32'h4;
  wire logic [31:0] d8 = {24'h0, instr[7:0]};
  // Expected values worked out from the inputs
  wire logic [31:0] e_post = rs + st;
  wire logic [31:0] e_mac = rd + st;
  wire logic [31:0] e_pre = rd - st;
  wire logic [31:0] e_idx = rs + index_register_zero;
  wire logic [31:0] e_gbr = global_base_register + d8 * st;
  wire logic [31:0] e_pcd = (pc & (size_sel[1] ? EAG_PC_LONG_MASK : '1))
    + d8 * st;
  wire logic [31:0] e_b8 = pc + {{23{instr[7]}}, instr[7:0], 1'b0};
  wire logic [31:0] e_b12 = pc + {{19{instr[11]}}, instr[11:0], 1'b0};
  wire logic [31:0] e_imm = imm_sel == EAG_I_SIGN ?
    {{24{instr[7]}}, instr[7:0]} : imm_sel == EAG_I_TRAP ? d8 << 2 : d8;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // One accepted request of a given mode
  sequence s_req(logic [13:0] m);
    rst_b && clk_en && op_valid && mode_sel == m;
  endsequence
  a_direct_no_access: assert property (
    s_req(EAG_M_REG_DIRECT) |=> operand_q == $past(rs) && !mem_access_q)
    else $error("direct operand wrong");
  a_indirect_addr: assert property (
    s_req(EAG_M_REG_IND) |=> ea_q == $past(rs) && mem_access_q)
    else $error("indirect address wrong");
  a_post_inc_wb: assert property (
    s_req(EAG_M_POST_INC) |=> ea_q == $past(rs) && wb_a_en_q &&
    wb_a_data_q == $past(e_post)) else $error("post increment wrong");
  a_pre_dec_wb: assert property (
    s_req(EAG_M_PRE_DEC) |=> ea_q == $past(e_pre) && wb_b_en_q &&
    wb_b_data_q == ea_q) else $error("pre decrement wrong");
  a_indexed_sum: assert property (
    s_req(EAG_M_INDEXED) |=> ea_q == $past(e_idx))
    else $error("indexed address wrong");
  a_gbr_disp_addr: assert property (
    s_req(EAG_M_GBR_DISP) |=> ea_q == $past(e_gbr))
    else $error("global base displacement wrong");
  a_pc_disp_addr: assert property (
    s_req(EAG_M_PC_DISP) ##0 size_sel != 2'h0 |=> ea_q == $past(e_pcd))
    else $error("pc displacement wrong");
  a_short_branch: assert property (
    s_req(EAG_M_BR_SHORT) |=> target_q == $past(e_b8))
    else $error("short branch target wrong");
  a_long_branch: assert property (
    s_req(EAG_M_BR_LONG) |=> target_q == $past(e_b12))
    else $error("long branch target wrong");
  a_imm_extend: assert property (
    s_req(EAG_M_IMM) |=> imm_q == $past(e_imm))
    else $error("immediate extension wrong");
  a_mac_two_ptrs: assert property (
    s_req(EAG_M_MAC) |=> wb_a_en_q && wb_b_en_q && mac_dest_q &&
    wb_a_data_q == $past(e_post) && wb_b_data_q == $past(e_mac))
    else $error("mac pointers wrong");
endmodule
bind eag_top eag_chk eag_chk_inst (.*);
`default_nettype wire

// ==== test/eag_rf_model.sv ====
// Register file model behind the address generator.
// Assumes write-backs arrive on the clock edge after the result.
`timescale 1ns/100ps
`default_nettype none
module eag_rf_model (
  input wire logic clk_sys,
  input wire logic [15:0] instr,
  input wire logic wa_en,
  input wire logic [3:0] wa_idx,
  input wire logic [31:0] wa_data,
  input wire logic wb_en,
  input wire logic [3:0] wb_idx,
  input wire logic [31:0] wb_data,
  output logic [31:0] src_val,
  output logic [31:0] dst_val,
  output logic [31:0] r0_val
);
  logic [31:0] regs_q [16];
  // Known start values: 0x100 per index plus 8
  initial for (int k = 0; k < 16; k++) regs_q[k] = 32'h100 * k + 32'h8;
  // Both write-back ports land on the edge
  always @(posedge clk_sys) begin
    if (wa_en) regs_q[wa_idx] <= wa_data;
    if (wb_en) regs_q[wb_idx] <= wb_data;
  end
  // Read ports follow the fields of the word
  assign src_val = regs_q[instr[7:4]];
  assign dst_val = regs_q[instr[11:8]];
  assign r0_val = regs_q[0];
endmodule
`default_nettype wire

// ==== test/eag_tb_top.sv ====
// Testbench for the address generator with a register file model.
// Assumes one result per request, one cycle after it is taken.
`timescale 1ns/100ps
`default_nettype none
module eag_tb_top import eag_pkg::*;;
  logic clk_sys, rst_b, clk_en, op_valid;
  logic [15:0] instr;
  logic [13:0] mode_sel;
  logic [2:0] imm_sel;
  logic [1:0] size_sel;
  logic [31:0] source_general_register, destination_general_register;
  logic [31:0] index_register_zero, global_base_register, pc_value;
  logic res_valid_q, mem_access_q, operand_valid_q, target_valid_q;
  logic imm_valid_q, wb_a_en_q, wb_b_en_q, mac_dest_q;
  logic [3:0] wb_a_idx_q, wb_b_idx_q;
  logic [31:0] ea_q, operand_q, target_q, imm_q, wb_a_data_q, wb_b_data_q;
  int n_fail = 0;
  int check_count = 0;
  eag_top eag_top_inst (.*);
  eag_rf_model eag_rf_model_inst (.clk_sys, .instr, .wa_en(wb_a_en_q),
    .wa_idx(wb_a_idx_q), .wa_data(wb_a_data_q), .wb_en(wb_b_en_q),
    .wb_idx(wb_b_idx_q), .wb_data(wb_b_data_q),
    .src_val(source_general_register),
    .dst_val(destination_general_register), .r0_val(index_register_zero));
  // 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic complete_run;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
      n_fail++;
    end
  endtask
  // One request, result read one cycle later
  task automatic req(input logic [13:0] m, input logic [1:0] s,
      input logic [15:0] w, input logic [2:0] i = 3'h1);
    @(posedge clk_sys);
    op_valid <= 1'b1;
    mode_sel <= m;
    size_sel <= s;
    instr <= w;
    imm_sel <= i;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    #1;
    chk(res_valid_q, 1'b1);
  endtask
  // Post-increment on register 3 for each size
  task automatic t_post;
    logic [31:0] a;
    a = 32'h308;
    for (int s = 0; s < 3; s++) begin
      req(EAG_M_POST_INC, s[1:0], 16'h0030);
      chk(ea_q, a);
      chk(wb_a_data_q, a + (32'h1 << s));
      chk({mem_access_q, wb_a_en_q, wb_a_idx_q}, 6'h33);
      a = a + (32'h1 << s);
    end
    req(EAG_M_REG_IND, 2'h0, 16'h0030);
    chk(ea_q, a);
  endtask
  // Pre-decrement on register 5 for each size
  task automatic t_pre;
    logic [31:0] a;
    a = 32'h508;
    for (int s = 0; s < 3; s++) begin
      a = a - (32'h1 << s);
      req(EAG_M_PRE_DEC, s[1:0], 16'h0500);
      chk(ea_q, a);
      chk(wb_b_data_q, a);
      chk({wb_b_en_q, wb_b_idx_q}, 5'h15);
    end
  endtask
  // Register and global base displacement and indexed forms
  task automatic t_disp;
    for (int s = 0; s < 3; s++) begin
      req(EAG_M_REG_DISP, s[1:0], 16'h002f);
      chk(ea_q, 32'h208 + (32'hf << s));
    end
    req(EAG_M_REG_DISP, 2'h3, 16'h002f);
    chk(ea_q, 32'h244);
    req(EAG_M_INDEXED, 2'h2, 16'h0020);
    chk(ea_q, 32'h210);
    req(EAG_M_GBR_DISP, 2'h2, 16'h00ff);
    chk(ea_q, 32'h400003fc);
    req(EAG_M_GBR_INDEX, 2'h0, 16'h00ff);
    chk(ea_q, 32'h40000008);
  endtask
  // PC displacement and branch targets, PC is unaligned
  task automatic t_pc;
    req(EAG_M_PC_DISP, 2'h1, 16'h0010);
    chk(ea_q, 32'h1023);
    req(EAG_M_PC_DISP, 2'h2, 16'h0310);
    chk(ea_q, 32'h1040);
    chk({wb_b_en_q, wb_b_idx_q}, 5'h03);
    req(EAG_M_BR_SHORT, 2'h0, 16'h0080);
    chk(target_q, 32'h0f03);
    req(EAG_M_BR_LONG, 2'h0, 16'h0800);
    chk(target_q, 32'h3);
    req(EAG_M_BR_REG, 2'h0, 16'h0020);
    chk({target_valid_q, target_q}, {1'b1, 32'h120b});
  endtask
  // Immediate extension for each handling code
  task automatic t_imm;
    req(EAG_M_IMM, 2'h0, 16'h0080, EAG_I_ZERO);
    chk({imm_valid_q, imm_q}, {1'b1, 32'h80});
    req(EAG_M_IMM, 2'h0, 16'h0080, EAG_I_SIGN);
    chk(imm_q, 32'hffffff80);
    req(EAG_M_IMM, 2'h0, 16'h0080, EAG_I_TRAP);
    chk(imm_q, 32'h200);
  endtask
  // Direct operand and multiply-accumulate pointers
  task automatic t_misc;
    req(EAG_M_REG_DIRECT, 2'h2, 16'h0020);
    chk({mem_access_q, operand_valid_q, operand_q}, {2'b01, 32'h208});
    req(EAG_M_MAC, 2'h1, 16'h0760);
    chk(wb_a_data_q, 32'h60a);
    chk(wb_b_data_q, 32'h70a);
    chk({mac_dest_q, wb_a_idx_q, wb_b_idx_q}, 9'h167);
  endtask
  // Clock enable low freezes outputs, request taken once it rises
  task automatic t_hold;
    logic [31:0] e;
    @(posedge clk_sys);
    clk_en <= 1'b0;
    op_valid <= 1'b1;
    mode_sel <= EAG_M_REG_IND;
    instr <= 16'h0020;
    #1;
    e = ea_q;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({res_valid_q, ea_q}, {1'b0, e});
    @(posedge clk_sys);
    clk_en <= 1'b1;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    #1;
    chk({res_valid_q, ea_q}, {1'b1, 32'h208});
  endtask
  // Watchdog against a hang
  initial begin
    #100000;
    n_fail++;
    complete_run();
  end
  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    op_valid = 1'b0;
    instr = 16'h0;
    mode_sel = 14'h0;
    imm_sel = 3'h1;
    size_sel = 2'h0;
    global_base_register = 32'h40000000;
    pc_value = 32'h1003;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    #1;
    chk({res_valid_q, ea_q}, 33'h0);
    t_post();
    t_pre();
    t_disp();
    t_pc();
    t_imm();
    t_misc();
    t_hold();
    complete_run();
  end
endmodule
`default_nettype wire
